// [design/sdt_defines.vh]
// Constants of the split dual 8-bit reload timer: register offsets,
// field positions, reset values and prescale counts.
// Assumes inclusion by bare name from the timer module only.
//
// Function
// - Split enable makes two separate 8-bit counters.
// - Both halves auto-reload from their own registers.
// - High half counts only while run bit set.
// - Low half counts in split mode whatever the run bit.
// - High clock: sysclk, or alternate select field.
// - Low half has own select, shared field.
// - High flag sets on high half rollover.
// - Low flag sets on low half rollover in split mode only.
// - Interrupt on every high overflow when enabled.
// - Low flag enable adds low overflow interrupts.
// - Hardware never clears overflow flags itself.
`ifndef SDT_DEFINES_VH
`define SDT_DEFINES_VH

// ********************************************************
// Register byte offsets
// ********************************************************
`define SDT_OFS_CTRL        8'h00
`define SDT_OFS_STATUS      8'h04
`define SDT_OFS_MASK        8'h08
`define SDT_OFS_COUNT       8'h0C
`define SDT_OFS_RELOAD      8'h10

// ********************************************************
// Control register fields
// ********************************************************
`define SDT_CTL_ALT_LO      0
`define SDT_CTL_ALT_HI      1
`define SDT_CTL_RUN         2
`define SDT_CTL_HSYS        3
`define SDT_CTL_LSYS        4
`define SDT_CTL_LFIE        5
`define SDT_CTL_TIE         6
`define SDT_CTL_SPLIT       7
`define SDT_CTL_RESET       8'h00

// ********************************************************
// Status and mask fields
// ********************************************************
`define SDT_ST_LOW          0
`define SDT_ST_HIGH         1

// ********************************************************
// Alternate clock codes and prescale counts
// ********************************************************
`define SDT_ALT_DIV12       2'h0
`define SDT_ALT_CMP         2'h1
`define SDT_ALT_RSVD        2'h2
`define SDT_ALT_EXT8        2'h3
`define SDT_DIV12_LAST      4'hB
`define SDT_DIV8_LAST       3'h7

`endif

// [design/sdt_timer.v]
// Split dual 8-bit auto-reload timer with an AHB-Lite register slave.
// Assumes one clock, a single AHB-Lite master and asynchronous pin inputs
// for the external clock and the comparator output.
//
// Added by the designer: the AHB-Lite slave port and the register addresses.
`timescale 1ns/100ps
`include "sdt_defines.vh"

module sdt_timer
(
	// Clock and reset
	input  wire        clock,
	input  wire        rst_b,
	// AHB-Lite slave
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output reg  [31:0] hrdata,
	output reg         hreadyout,
	output reg         hresp,
	// Count source pins
	input  wire        ext_clk_in,
	input  wire        cmp1_in,
	// Interrupt
	output reg         irq
);

// ********************************************************
// Declarations
// ********************************************************
reg  [7:0]  ctrl_r;
reg  [1:0]  status_r;
reg  [1:0]  mask_r;
reg  [7:0]  timer_low_half_r;
reg  [7:0]  timer_high_half_r;
reg  [7:0]  reload_low_value_r;
reg  [7:0]  reload_high_value_r;
reg  [1:0]  ext_sync_r;
reg  [1:0]  cmp_sync_r;
reg         ext_prev_r;
reg         cmp_prev_r;
reg  [3:0]  div12_r;
reg  [2:0]  div8_r;
reg         wr_pend_r;
reg  [7:0]  wr_addr_r;
reg  [31:0] rdata_nxt;
reg  [7:0]  low_nxt;
reg  [7:0]  high_nxt;
reg         low_ovf;
reg         high_ovf;
reg  [1:0]  status_nxt;
reg         irq_nxt;

wire [1:0]  alt_clock_select;
wire        split_enable;
wire        high_half_run;
wire        high_sysclk_select;
wire        low_sysclk_select;
wire        low_flag_irq_enable;
wire        timer_irq_enable;
wire        tick_div12;
wire        tick_ext8;
wire        tick_cmp;
wire        ext_rise;
wire        high_tick;
wire        low_tick;
wire        addr_ok;
wire        wr_ctrl;
wire        wr_status;
wire        wr_mask;
wire        wr_count;
wire        wr_reload;
wire [8:0]  low_step;
wire [8:0]  high_step;

assign alt_clock_select    = ctrl_r[`SDT_CTL_ALT_HI:`SDT_CTL_ALT_LO];
assign split_enable        = ctrl_r[`SDT_CTL_SPLIT];
assign high_half_run       = ctrl_r[`SDT_CTL_RUN];
assign high_sysclk_select  = ctrl_r[`SDT_CTL_HSYS];
assign low_sysclk_select   = ctrl_r[`SDT_CTL_LSYS];
assign low_flag_irq_enable = ctrl_r[`SDT_CTL_LFIE];
assign timer_irq_enable    = ctrl_r[`SDT_CTL_TIE];

// ********************************************************
// Count source selection
// ********************************************************
// The reserved code gives no ticks, so a half left on it stands still.
function sel_tick;
	input       sys_sel;
	input [1:0] alt;
	input       t12;
	input       tcmp;
	input       text;
	begin
		if (sys_sel)
			sel_tick = 1'b1;
		else
		begin
			case (alt)
				`SDT_ALT_DIV12: sel_tick = t12;
				`SDT_ALT_CMP:   sel_tick = tcmp;
				`SDT_ALT_EXT8:  sel_tick = text;
				default:        sel_tick = 1'b0;
			endcase
		end
	end
endfunction

assign high_tick = sel_tick(high_sysclk_select, alt_clock_select,
	tick_div12, tick_cmp, tick_ext8);
assign low_tick  = sel_tick(low_sysclk_select, alt_clock_select,
	tick_div12, tick_cmp, tick_ext8);

// ********************************************************
// Pin synchronisers and prescalers
// ********************************************************
assign ext_rise   = ext_sync_r[1] & ~ext_prev_r;
assign tick_cmp   = cmp_sync_r[1] & ~cmp_prev_r;
assign tick_div12 = (div12_r == `SDT_DIV12_LAST);
assign tick_ext8  = ext_rise & (div8_r == `SDT_DIV8_LAST);

always @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
	begin
		ext_sync_r <= 2'h0;
		cmp_sync_r <= 2'h0;
		ext_prev_r <= 1'b0;
		cmp_prev_r <= 1'b0;
		div12_r    <= 4'h0;
		div8_r     <= 3'h0;
	end
	else
	begin
		ext_sync_r <= {ext_sync_r[0], ext_clk_in};
		cmp_sync_r <= {cmp_sync_r[0], cmp1_in};
		ext_prev_r <= ext_sync_r[1];
		cmp_prev_r <= cmp_sync_r[1];
		if (tick_div12)
			div12_r <= 4'h0;
		else
			div12_r <= div12_r + 4'h1;
		if (ext_rise)
			div8_r <= div8_r + 3'h1;
	end
end

// ********************************************************
// Counters
// ********************************************************
// One step of an 8-bit half: at the top it takes the reload value, and
// bit 8 reports the overflow.
function [8:0] half_step;
	input [7:0] count;
	input [7:0] reload;
	begin
		if (count == 8'hFF)
			half_step = {1'b1, reload};
		else
			half_step = {1'b0, count + 8'h01};
	end
endfunction

assign low_step  = half_step(timer_low_half_r, reload_low_value_r);
assign high_step = half_step(timer_high_half_r, reload_high_value_r);

// In 16-bit mode the pair counts as one word on the high half's source.
always @*
begin
	low_nxt  = timer_low_half_r;
	high_nxt = timer_high_half_r;
	low_ovf  = 1'b0;
	high_ovf = 1'b0;
	if (split_enable)
	begin
		if (low_tick)
		begin
			low_ovf = low_step[8];
			low_nxt = low_step[7:0];
		end
		if (high_half_run && high_tick)
		begin
			high_ovf = high_step[8];
			high_nxt = high_step[7:0];
		end
	end
	else if (high_half_run && high_tick)
	begin
		if ({timer_high_half_r, timer_low_half_r} == 16'hFFFF)
		begin
			high_ovf = 1'b1;
			low_nxt  = reload_low_value_r;
			high_nxt = reload_high_value_r;
		end
		else
			{high_nxt, low_nxt} = {timer_high_half_r, timer_low_half_r} + 16'h0001;
	end
end

// ********************************************************
// Bus slave
// ********************************************************
assign addr_ok   = hsel & htrans[1] & hready;
assign wr_ctrl   = wr_pend_r & (wr_addr_r == `SDT_OFS_CTRL);
assign wr_status = wr_pend_r & (wr_addr_r == `SDT_OFS_STATUS);
assign wr_mask   = wr_pend_r & (wr_addr_r == `SDT_OFS_MASK);
assign wr_count  = wr_pend_r & (wr_addr_r == `SDT_OFS_COUNT);
assign wr_reload = wr_pend_r & (wr_addr_r == `SDT_OFS_RELOAD);

// Read data is fetched in the address phase so that it leaves a flop.
always @*
begin
	rdata_nxt = 32'h00000000;
	case (haddr[7:0])
		`SDT_OFS_CTRL:   rdata_nxt[7:0]  = ctrl_r;
		`SDT_OFS_STATUS: rdata_nxt[1:0]  = status_r;
		`SDT_OFS_MASK:   rdata_nxt[1:0]  = mask_r;
		`SDT_OFS_COUNT:  rdata_nxt[15:0] = {timer_high_half_r, timer_low_half_r};
		`SDT_OFS_RELOAD: rdata_nxt[15:0] = {reload_high_value_r, reload_low_value_r};
		default:         rdata_nxt = 32'h00000000;
	endcase
	if (haddr[31:8] != 24'h000000)
		rdata_nxt = 32'h00000000;
end

always @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
	begin
		hrdata    <= 32'h00000000;
		hreadyout <= 1'b0;
		hresp     <= 1'b0;
		wr_pend_r <= 1'b0;
		wr_addr_r <= 8'h00;
	end
	else
	begin
		hreadyout <= 1'b1;
		hresp     <= 1'b0;
		wr_pend_r <= addr_ok & hwrite & (haddr[31:8] == 24'h000000);
		wr_addr_r <= haddr[7:0];
		if (addr_ok && !hwrite)
			hrdata <= rdata_nxt;
	end
end

// ********************************************************
// Registers, flags and interrupt
// ********************************************************
// A set arriving with a write-one clear wins, so no overflow is lost.
always @*
begin
	status_nxt = status_r;
	if (wr_status)
		status_nxt = status_r & ~hwdata[1:0];
	if (low_ovf)
		status_nxt[`SDT_ST_LOW] = 1'b1;
	if (high_ovf)
		status_nxt[`SDT_ST_HIGH] = 1'b1;
	irq_nxt = timer_irq_enable & (
		(status_nxt[`SDT_ST_HIGH] & mask_r[`SDT_ST_HIGH]) |
		(low_flag_irq_enable & status_nxt[`SDT_ST_LOW] &
		 mask_r[`SDT_ST_LOW]));
end

always @(posedge clock or negedge rst_b)
begin
	if (!rst_b)
	begin
		ctrl_r              <= `SDT_CTL_RESET;
		status_r            <= 2'h0;
		mask_r              <= 2'h0;
		timer_low_half_r    <= 8'h00;
		timer_high_half_r   <= 8'h00;
		reload_low_value_r  <= 8'h00;
		reload_high_value_r <= 8'h00;
		irq                 <= 1'b0;
	end
	else
	begin
		status_r <= status_nxt;
		irq      <= irq_nxt;
		if (wr_ctrl)
			ctrl_r <= hwdata[7:0];
		if (wr_mask)
			mask_r <= hwdata[1:0];
		if (wr_reload)
		begin
			reload_low_value_r  <= hwdata[7:0];
			reload_high_value_r <= hwdata[15:8];
		end
		if (wr_count)
		begin
			timer_low_half_r  <= hwdata[7:0];
			timer_high_half_r <= hwdata[15:8];
		end
		else
		begin
			timer_low_half_r  <= low_nxt;
			timer_high_half_r <= high_nxt;
		end
	end
end

endmodule // sdt_timer

// [verif/sdt_timer_assertions.sv]
// Checker for the split reload timer's bus and interrupt ports.
// Assumes a single AHB-Lite master with hready tied to hreadyout.
`timescale 1ns/100ps
module sdt_timer_assertions
(
	// Clock and reset
	input wire        clock,
	input wire        rst_b,
	// Bus and interrupt
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire        hready,
	input wire [31:0] hrdata,
	input wire        hreadyout,
	input wire        hresp,
	input wire        irq
);
	wire rd = hsel && htrans[1] && hready && !hwrite;
	wire wr = hsel && htrans[1] && hready && hwrite;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_b);
	ctrl_width_a: assert property (rd && haddr == 32'h0 |=> hrdata[31:8] == 24'h0)
		else $error("control read too wide");
	count_width_a: assert property (rd && haddr == 32'hC |=> hrdata[31:16] == 16'h0)
		else $error("count read too wide");
	reload_width_a: assert property (rd && haddr == 32'h10 |=> hrdata[31:16] == 16'h0)
		else $error("reload read too wide");
	flag_width_a: assert property (rd && haddr == 32'h4 |=> hrdata[31:2] == 30'h0)
		else $error("status read too wide");
	irq_hold_a: assert property ($fell(irq) |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4))
		else $error("interrupt dropped without a write");
	rdata_hold_a: assert property (!$stable(hrdata) |-> $past(rd))
		else $error("read data moved without a read");
	unmapped_zero_a: assert property (rd && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	ready_okay_a: assert property ($past(rst_b) |-> hreadyout && !hresp)
		else $error("bus not ready or not okay");
	cover property (rd && haddr == 32'h4);
	cover property ($rose(irq));
	cover property ($fell(irq));
endmodule // sdt_timer_assertions

bind sdt_timer sdt_timer_assertions sdt_timer_assertions_i (.*);

// [verif/split_dual_8bit_reload_timer_test.sv]
// Self-checking bench for the split reload timer over AHB-Lite.
// Assumes the register map and zero wait states of the timer.
`timescale 1ns/100ps
module split_dual_8bit_reload_timer_test;
	reg        clock, rst_b, hsel, hwrite, ext_clk_in, cmp1_in;
	reg [31:0] haddr, hwdata, v, rd_s;
	reg        rdy_s, irq_s;
	reg [1:0]  htrans;
	wire [31:0] hrdata;
	wire       hreadyout, hresp, irq;
	integer    fails, n_compared, i, j, k;
	sdt_timer sdt_timer_i
	(
		.clock      (clock),
		.rst_b      (rst_b),
		.hsel       (hsel),
		.haddr      (haddr),
		.htrans     (htrans),
		.hwrite     (hwrite),
		.hsize      (3'h2),
		.hwdata     (hwdata),
		.hready     (hreadyout),
		.hrdata     (hrdata),
		.hreadyout  (hreadyout),
		.hresp      (hresp),
		.ext_clk_in (ext_clk_in),
		.cmp1_in    (cmp1_in),
		.irq        (irq)
	);
	// Settled copies of the outputs, taken away from the edge that launches them.
	always @(negedge clock)
	begin
		rdy_s = hreadyout;
		rd_s  = hrdata;
		irq_s = irq;
	end
	initial
	begin
		clock = 0;
		forever #12.5 clock = ~clock;
	end
	task finish_test;
	begin
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	task chk(input [31:0] s, input [31:0] e);
	begin
		n_compared = n_compared + 1;
		if (s !== e)
		begin
			fails = fails + 1;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	end
	endtask
	// Waits for hready high at a rising edge, bounded.
	task rdy;
	begin
		k = 0;
		@(posedge clock);
		while (rdy_s !== 1'b1)
		begin
			k = k + 1;
			if (k > 50)
			begin
				fails = fails + 1;
				finish_test;
			end
			@(posedge clock);
		end
	end
	endtask
	task acc(input wr, input [31:0] a, input [31:0] d);
	begin
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= wr;
		haddr <= a;
		rdy;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy;
		v = rd_s;
	end
	endtask
	task rc(input [31:0] a, input [31:0] e);
	begin
		acc(0, a, 0);
		chk(v, e);
	end
	endtask
	initial
	begin
		fails = 0;
		n_compared = 0;
		{rst_b, hsel, hwrite, ext_clk_in, cmp1_in, htrans, haddr, hwdata} = 0;
		repeat (20) @(posedge clock);
		rst_b <= 1'b1;
		repeat (2) @(posedge clock);
		for (i = 0; i < 5; i = i + 1)
			rc(i * 4, 0);
		acc(1, 32'h100, 32'hFF);
		rc(32'h100, 0);
		rc(32'h0, 0);
		acc(1, 32'h10, 32'h8080);
		rc(32'h10, 32'h8080);
		$display("test 1 done");
		// Low half on sysclk with the run bit clear.
		acc(1, 32'h8, 32'h3);
		acc(1, 32'hC, 32'hFE);
		acc(1, 32'h0, 32'hD8);
		repeat (40) @(posedge clock);
		rc(32'h4, 32'h1);
		chk(irq_s, 0);
		acc(0, 32'hC, 0);
		chk(v & 32'hFF80, 32'h80);
		acc(1, 32'h0, 32'hE9);
		repeat (3) @(posedge clock);
		chk(irq_s, 1);
		acc(1, 32'h4, 32'h3);
		repeat (3) @(posedge clock);
		rc(32'h4, 0);
		chk(irq_s, 0);
		$display("test 2 done");
		// High half on sysclk with the low half held on a quiet comparator.
		acc(1, 32'hC, 32'hFE00);
		acc(1, 32'h0, 32'hCD);
		repeat (8) @(posedge clock);
		rc(32'h4, 32'h2);
		chk(irq_s, 1);
		acc(0, 32'hC, 0);
		chk(v & 32'h80FF, 32'h8000);
		acc(1, 32'h0, 32'hC9);
		acc(1, 32'hC, 32'h9000);
		repeat (20) @(posedge clock);
		rc(32'hC, 32'h9000);
		// With split clear the pair carries as one word and sets no low flag.
		acc(1, 32'h4, 32'h3);
		acc(1, 32'hC, 32'hFE);
		acc(1, 32'h0, 32'h4C);
		repeat (10) @(posedge clock);
		acc(0, 32'hC, 0);
		chk(v & 32'hFF00, 32'h100);
		rc(32'h4, 0);
		$display("test 3 done");
		// Low half on each alternate source; the reserved code is never set.
		for (i = 0; i < 4; i = i + 1)
		begin
			if (i != 2)
			begin
				acc(1, 32'h0, 32'h81);
				acc(1, 32'h4, 32'h3);
				acc(1, 32'hC, 32'hFF);
				acc(1, 32'h0, 32'h80 | i);
				for (j = 0; j < 20; j = j + 1)
				begin
					ext_clk_in <= ~ext_clk_in;
					cmp1_in <= ~cmp1_in;
					repeat (2) @(posedge clock);
				end
				repeat (6) @(posedge clock);
				rc(32'h4, 32'h1);
			end
		end
		$display("test 4 done");
		finish_test;
	end
endmodule // split_dual_8bit_reload_timer_test
